// *** tb/test_word_width_mailbox_bridge.sv ***
// Testbench of the mailbox bridge with both ends joined
module test_word_width_mailbox_bridge
  import wmb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic       sys_clk_i     = 1'b0;
  logic       srst_i        = 1'b1;
  logic       hw_valid_i    = 1'b0;
  wmb_word_t  hw_word_i     = 36'h000000000;
  logic       host_finish_i = 1'b0;
  logic       sw_valid_i    = 1'b0;
  wmb_word_t  sw_word_i     = 36'h000000000;
  logic       hw_ready_o;
  logic       hr_valid_o;
  logic       sr_valid_o;
  logic       sw_ready_o;
  wmb_word_t  hr_word_o;
  wmb_word_t  sr_word_o;
  logic [4:0] flags_o;
  logic       stall         = 1'b0;
  int         error_cnt     = 0;
  int         compares      = 0;
  int         cyc           = 0;
  wmb_word_t  sr_q[$];
  wmb_word_t  hr_q[$];
  always #4 sys_clk_i = ~sys_clk_i;
  // ==========================================================
  // Design
  wmb_link_if link ();
  wmb_bridge_dev #(.SAT_MODE(WMB_MODE_12)) u_wmb_bridge_dev (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .link(link), .flags_o(flags_o));
  wmb_bridge_far #(.SAT_MODE(WMB_MODE_12)) u_wmb_bridge_far (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .link(link),
    .hw_valid_i(hw_valid_i), .hw_word_i(hw_word_i), .hw_ready_o(hw_ready_o),
    .host_finish_i(host_finish_i), .hr_valid_o(hr_valid_o), .hr_word_o(hr_word_o),
    .sw_valid_i(sw_valid_i), .sw_word_i(sw_word_i), .sw_ready_o(sw_ready_o),
    .sr_valid_o(sr_valid_o), .sr_word_o(sr_word_o));
  wmb_link_chk #(.SAT_MODE(WMB_MODE_12)) u_wmb_link_chk (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .host_sel(link.host_sel),
    .host_dout_set(link.host_dout_set), .host_din(link.host_din),
    .host_cin(link.host_cin), .host_cout(link.host_cout),
    .host_rdata(link.host_rdata), .host_rdata_vld(link.host_rdata_vld),
    .host_interrupt_request(link.host_interrupt_request),
    .sat_test_full(link.sat_test_full), .sat_test_empty(link.sat_test_empty),
    .sat_read(link.sat_read), .skip_request(link.skip_request),
    .satellite_interrupt_request(link.satellite_interrupt_request),
    .read_request(link.read_request));
  // ==========================================================
  // Helpers
  function automatic wmb_word_t pat(int i);
    return 36'h9A5C3E17B ^ {9{i[3:0]}};
  endfunction
  task automatic chk(string n, wmb_word_t e, wmb_word_t s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic host_put(wmb_word_t w);
    @(negedge sys_clk_i);
    hw_valid_i = 1'b1;
    hw_word_i = w;
    @(posedge sys_clk_i);
    while (hw_ready_o !== 1'b1) begin
      stall = 1'b1;
      @(posedge sys_clk_i);
    end
  endtask
  task automatic sat_put(wmb_word_t w);
    @(negedge sys_clk_i);
    sw_valid_i = 1'b1;
    sw_word_i = w;
    @(posedge sys_clk_i iff sw_ready_o === 1'b1);
    @(negedge sys_clk_i);
    sw_valid_i = 1'b0;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (sr_valid_o === 1'b1) sr_q.push_back(sr_word_o);
    if (hr_valid_o === 1'b1) hr_q.push_back(hr_word_o);
    if (cyc == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("flags_reset", 36'h000000009, {31'h00000000, flags_o});
    srst_i = 1'b0;
    fork
      begin
        for (int i = 0; i < 20; i++) host_put(pat(i));
        @(negedge sys_clk_i);
        hw_valid_i = 1'b0;
      end
      for (int j = 0; j < 3; j++) sat_put(~pat(j));
    join
    wait (sr_q.size() == 20 && hr_q.size() == 3);
    chk("fifo_stall", 36'h000000001, {35'h000000000, stall});
    for (int i = 0; i < 20; i++) chk("sat_word", pat(i), sr_q[i]);
    for (int j = 0; j < 3; j++) chk("host_word", ~pat(j), hr_q[j]);
    repeat (20) @(negedge sys_clk_i);
    chk("flags_idle", 36'h000000009, {31'h00000000, flags_o});
    host_finish_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    chk("flags_done", 36'h000000000, {31'h00000000, flags_o});
    end_sim();
  end
endmodule

// *** tb/wmb_link_chk.sv ***
// Checker of the link between the two bridge ends
module wmb_link_chk
  import wmb_pkg::*;
#(
  parameter wmb_mode_e SAT_MODE = WMB_MODE_12
) (
  // Clock and reset
  input wire logic      sys_clk_i,
  input wire logic      srst_i,
  // Host group
  input wire logic      host_sel,
  input wire logic      host_dout_set,
  input wire logic      host_din,
  input wire logic      host_cin,
  input wire logic      host_cout,
  input wire wmb_word_t host_rdata,
  input wire logic      host_rdata_vld,
  input wire logic      host_interrupt_request,
  // Satellite group
  input wire logic      sat_test_full,
  input wire logic      sat_test_empty,
  input wire logic      sat_read,
  input wire logic      skip_request,
  input wire logic      satellite_interrupt_request,
  input wire logic      read_request
);
  // ==========================================================
  // Read counter
  logic [1:0] rd_cnt_q;
  logic [1:0] rd_cnt_d;
  logic [1:0] last;
  assign last = (SAT_MODE == WMB_MODE_12) ? 2'h2 : 2'h1;
  always_comb begin
    rd_cnt_d = rd_cnt_q;
    if (host_sel && host_dout_set) begin
      rd_cnt_d = 2'h0;
    end else if (sat_read) begin
      rd_cnt_d = rd_cnt_q + 2'h1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    rd_cnt_q <= srst_i ? 2'h0 : rd_cnt_d;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence cin_s;
    host_sel && host_cin;
  endsequence
  sequence set_s;
    host_sel && host_dout_set;
  endsequence
  stat_vld_a: assert property (cin_s |=> host_rdata_vld)
    else $error("no status answer");
  stat_fmt_a: assert property (cin_s |=> host_rdata[35:33] == 3'h0 && host_rdata[27:0] == 28'h0)
    else $error("status word has stray bits");
  vld_cause_a: assert property (host_rdata_vld |-> $past(host_sel && (host_cin || host_din)))
    else $error("host answer without request");
  skip_cause_a: assert property (skip_request |-> $past(sat_test_full || sat_test_empty))
    else $error("skip without test");
  skip_full_a: assert property (set_s ##[1:4] sat_test_full |=> skip_request)
    else $error("no skip on full buffer");
  sat_irq_a: assert property (set_s |-> ##[1:2] satellite_interrupt_request)
    else $error("no satellite request after send");
  rd_req_a: assert property (sat_read |=> read_request == (SAT_MODE == WMB_MODE_18))
    else $error("read request wrong");
  last_read_a: assert property (sat_read && rd_cnt_q == last |-> ##[1:2] host_interrupt_request)
    else $error("no host request after last read");
  din_irq_a: assert property (host_sel && host_din |-> ##[1:2] satellite_interrupt_request)
    else $error("no satellite request after data input");
  cout_clr_a: assert property (host_sel && host_cout |-> ##2 !host_interrupt_request)
    else $error("host request stays after condition output");
endmodule

// *** verilog/wmb_bridge_dev.sv ***
// Mailbox bridge device end: buffers, flags and transfer control
// Notes on behaviour
// - Two 36-bit buffers and five status flags
// - Data output clears, loads buffer, sets full
// - Outbound full raises satellite interrupt request
// - Outbound full test returns a skip
// - Each read drives one outbound piece out
// - Wide mode drives read request per read
// - Three 12-bit or two 18-bit reads
// - Final read sets empty, clears full
// - Outbound empty raises host interrupt request
// - Condition input returns status flags to host
// - Condition output clears flags, drops host request
// - Clear pulse zeroes inbound buffer, clears empty
// - Load pulses gate satellite pieces inbound
// - Final load sets inbound full, host request
// - Data input returns word, empty set, full cleared
// - After data input, request moves to satellite
// - Inbound empty test returns a skip
// - Satellite clears buffer before each load sequence
// - Host sends only after seeing outbound empty, or once idle after its condition output
// - Data output comes as clear then set 1us
// - Clear phase also clears outbound empty
// - Outbound empty appears on status bit 28
// - Narrow pieces land low, middle, high
`include "wmb_consts.svh"
module wmb_bridge_dev
  import wmb_pkg::*;
#(
  parameter wmb_mode_e SAT_MODE = WMB_MODE_12
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // Link to host and satellite
  wmb_link_if.dev         link,
  // Flag view
  output logic [4:0]      flags_o
);

  // ==========================================================
  // State
  wmb_word_t  ob_q,        ob_d;
  wmb_word_t  ib_q,        ib_d;
  logic       of_q,        of_d;
  logic       oe_q,        oe_d;
  logic       if_q,        if_d;
  logic       ie_q,        ie_d;
  logic       lda_q,       lda_d;
  wmb_idx_t   rd_idx_q,    rd_idx_d;
  wmb_idx_t   ld_idx_q,    ld_idx_d;
  wmb_word_t  hrd_q,       hrd_d;
  logic       hvld_q,      hvld_d;
  logic       hirq_q,      hirq_d;
  wmb_piece_t srd_q,       srd_d;
  logic       skip_q,      skip_d;
  logic       sirq_q,      sirq_d;
  logic       rdrq_q,      rdrq_d;
  logic [4:0] flags_q,     flags_d;
  wmb_word_t  status;
  logic       sel;
  logic       rd_last;
  logic       ld_last;

  // ==========================================================
  // Status word
  always_comb begin
    status                    = '0;
    status[`WMB_ST_OUT_EMPTY] = oe_q;
    status[`WMB_ST_OUT_FULL]  = of_q;
    status[`WMB_ST_IN_FULL]   = if_q;
    status[`WMB_ST_IN_EMPTY]  = ie_q;
    status[`WMB_ST_LOADING]   = lda_q;
  end

  assign sel     = link.host_sel;
  assign rd_last = (rd_idx_q == wmb_last_idx(SAT_MODE));
  assign ld_last = (ld_idx_q == wmb_last_idx(SAT_MODE));

  // ==========================================================
  // Next state: clears first, so a set in the same cycle wins
  always_comb begin
    ob_d     = ob_q;
    ib_d     = ib_q;
    of_d     = of_q;
    oe_d     = oe_q;
    if_d     = if_q;
    ie_d     = ie_q;
    lda_d    = lda_q;
    rd_idx_d = rd_idx_q;
    ld_idx_d = ld_idx_q;
    hrd_d    = hrd_q;
    hvld_d   = 1'b0;
    srd_d    = srd_q;
    rdrq_d   = 1'b0;
    // Host clears all flags
    if (sel && link.host_cout) begin
      of_d  = 1'b0;
      oe_d  = 1'b0;
      if_d  = 1'b0;
      ie_d  = 1'b0;
      lda_d = 1'b0;
    end
    // Clear phase of host data output
    if (sel && link.host_dout_clr) begin
      ob_d = '0;
      oe_d = 1'b0;
    end
    // Host reads inbound word
    if (sel && link.host_din) begin
      hrd_d  = ib_q;
      hvld_d = 1'b1;
      if_d   = 1'b0;
      ie_d   = 1'b1;
    end
    // Host reads status
    if (sel && link.host_cin) begin
      hrd_d  = status;
      hvld_d = 1'b1;
    end
    // Satellite clears inbound buffer
    if (link.sat_clear) begin
      ib_d     = '0;
      if (!(sel && link.host_din)) begin
        ie_d = 1'b0;
      end
      lda_d    = 1'b0;
      ld_idx_d = '0;
    end
    // Set phase of host data output
    if (sel && link.host_dout_set) begin
      ob_d = link.host_wdata;
      of_d = 1'b1;
    end
    // Satellite loads one piece
    if (link.sat_load) begin
      ib_d = wmb_piece_put(ib_d, link.sat_wdata, SAT_MODE, ld_idx_q);
      if (ld_last) begin
        if_d     = 1'b1;
        lda_d    = 1'b0;
        ld_idx_d = '0;
      end else begin
        lda_d    = 1'b1;
        ld_idx_d = ld_idx_q + 2'h1;
      end
    end
    // Satellite reads one piece
    if (link.sat_read) begin
      srd_d  = wmb_piece_get(ob_q, SAT_MODE, rd_idx_q);
      rdrq_d = (SAT_MODE == WMB_MODE_18);
      if (rd_last) begin
        oe_d     = 1'b1;
        rd_idx_d = '0;
        if (!(sel && link.host_dout_set)) begin
          of_d = 1'b0;
        end
      end else begin
        rd_idx_d = rd_idx_q + 2'h1;
      end
    end
    skip_d  = (link.sat_test_full && of_q) || (link.sat_test_empty && ie_q);
    hirq_d  = oe_d || if_d;
    sirq_d  = of_d || ie_d;
    flags_d = {lda_d, ie_d, if_d, of_d, oe_d};
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ob_q     <= '0;
      ib_q     <= '0;
      of_q     <= `WMB_RST_OUT_FULL;
      oe_q     <= `WMB_RST_OUT_EMPTY;
      if_q     <= `WMB_RST_IN_FULL;
      ie_q     <= `WMB_RST_IN_EMPTY;
      lda_q    <= `WMB_RST_LOADING;
      rd_idx_q <= '0;
      ld_idx_q <= '0;
      hrd_q    <= '0;
      hvld_q   <= 1'b0;
      hirq_q   <= 1'b0;
      srd_q    <= '0;
      skip_q   <= 1'b0;
      sirq_q   <= 1'b0;
      rdrq_q   <= 1'b0;
      flags_q  <= {`WMB_RST_LOADING, `WMB_RST_IN_EMPTY, `WMB_RST_IN_FULL,
                   `WMB_RST_OUT_FULL, `WMB_RST_OUT_EMPTY};
    end else begin
      ob_q     <= ob_d;
      ib_q     <= ib_d;
      of_q     <= of_d;
      oe_q     <= oe_d;
      if_q     <= if_d;
      ie_q     <= ie_d;
      lda_q    <= lda_d;
      rd_idx_q <= rd_idx_d;
      ld_idx_q <= ld_idx_d;
      hrd_q    <= hrd_d;
      hvld_q   <= hvld_d;
      hirq_q   <= hirq_d;
      srd_q    <= srd_d;
      skip_q   <= skip_d;
      sirq_q   <= sirq_d;
      rdrq_q   <= rdrq_d;
      flags_q  <= flags_d;
    end
  end

  // ==========================================================
  // Outputs
  assign link.host_rdata                  = hrd_q;
  assign link.host_rdata_vld              = hvld_q;
  assign link.host_interrupt_request      = hirq_q;
  assign link.sat_rdata                   = srd_q;
  assign link.skip_request                = skip_q;
  assign link.satellite_interrupt_request = sirq_q;
  assign link.read_request                = rdrq_q;
  assign flags_o                          = flags_q;

endmodule

// *** verilog/wmb_bridge_far.sv ***
// Far end of the mailbox bridge: host and satellite sequencers with send FIFO
`include "wmb_consts.svh"
module wmb_fifo #(
  parameter int W = `WMB_WORD_W,
  parameter int D = `WMB_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q,  wp_d;
  logic [AW-1:0] rp_q,  rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
endmodule

module wmb_bridge_far
  import wmb_pkg::*;
#(
  parameter wmb_mode_e SAT_MODE = WMB_MODE_12
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // Link to the device
  wmb_link_if.far         link,
  // Host user side
  input  wire logic       hw_valid_i,
  input  wire wmb_word_t  hw_word_i,
  output logic            hw_ready_o,
  input  wire logic       host_finish_i,
  output logic            hr_valid_o,
  output wmb_word_t       hr_word_o,
  // Satellite user side
  input  wire logic       sw_valid_i,
  input  wire wmb_word_t  sw_word_i,
  output logic            sw_ready_o,
  output logic            sr_valid_o,
  output wmb_word_t       sr_word_o
);
  localparam logic [7:0] GAP_LAST = 8'(`WMB_DOUT_GAP_CYC - 1);

  // ==========================================================
  // Host sequencer
  wmb_host_st_e hst_q,  hst_d;
  logic [7:0]   gap_q,  gap_d;
  logic         idle_q, idle_d;
  logic         clr_q,  clr_d;
  logic         set_q,  set_d;
  logic         din_q,  din_d;
  logic         cin_q,  cin_d;
  logic         cout_q, cout_d;
  wmb_word_t    hwd_q,  hwd_d;
  logic         hrv_q,  hrv_d;
  wmb_word_t    hrw_q,  hrw_d;
  logic         f_valid;
  wmb_word_t    f_data;
  logic         f_pop;
  logic         hwr_q;
  logic         f_ready;
  logic         can_send;

  wmb_fifo #(.W(`WMB_WORD_W), .D(`WMB_FIFO_DEPTH)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (hw_valid_i && hwr_q),
    .in_data_i   (hw_word_i),
    .in_ready_o  (f_ready),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (f_pop)
  );

  assign f_pop    = (hst_q == WMB_H_GAP) && (gap_q == GAP_LAST);
  assign can_send = link.host_rdata[`WMB_ST_OUT_EMPTY] || idle_q;

  always_comb begin
    hst_d  = hst_q;
    gap_d  = gap_q;
    idle_d = idle_q;
    clr_d  = 1'b0;
    set_d  = 1'b0;
    din_d  = 1'b0;
    cin_d  = 1'b0;
    cout_d = 1'b0;
    hwd_d  = hwd_q;
    hrv_d  = 1'b0;
    hrw_d  = hrw_q;
    unique case (hst_q)
      WMB_H_POLL: begin
        cin_d = 1'b1;
        hst_d = WMB_H_STAT;
      end
      WMB_H_STAT: begin
        if (link.host_rdata_vld) begin
          hst_d = WMB_H_POLL;
          if (link.host_rdata[`WMB_ST_IN_FULL]) begin
            din_d = 1'b1;
            hst_d = WMB_H_DWAIT;
          end else if (can_send && f_valid) begin
            clr_d  = 1'b1;
            gap_d  = '0;
            idle_d = 1'b0;
            hst_d  = WMB_H_GAP;
          end else if (host_finish_i && !f_valid && !idle_q &&
                       link.host_rdata[`WMB_ST_OUT_EMPTY]) begin
            cout_d = 1'b1;
            idle_d = 1'b1;
          end
        end
      end
      WMB_H_GAP: begin
        gap_d = gap_q + 8'h01;
        if (gap_q == GAP_LAST) begin
          set_d = 1'b1;
          hwd_d = f_data;
          hst_d = WMB_H_POLL;
        end
      end
      WMB_H_DWAIT: begin
        if (link.host_rdata_vld) begin
          hrv_d = 1'b1;
          hrw_d = link.host_rdata;
          hst_d = WMB_H_POLL;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hst_q  <= WMB_H_POLL;
      gap_q  <= '0;
      idle_q <= 1'b0;
      clr_q  <= 1'b0;
      set_q  <= 1'b0;
      din_q  <= 1'b0;
      cin_q  <= 1'b0;
      cout_q <= 1'b0;
      hwd_q  <= '0;
      hrv_q  <= 1'b0;
      hrw_q  <= '0;
      hwr_q  <= 1'b0;
    end else begin
      hst_q  <= hst_d;
      gap_q  <= gap_d;
      idle_q <= idle_d;
      clr_q  <= clr_d;
      set_q  <= set_d;
      din_q  <= din_d;
      cin_q  <= cin_d;
      cout_q <= cout_d;
      hwd_q  <= hwd_d;
      hrv_q  <= hrv_d;
      hrw_q  <= hrw_d;
      hwr_q  <= f_ready && !(hw_valid_i && hwr_q);
    end
  end

  // ==========================================================
  // Satellite sequencer
  wmb_sat_st_e sst_q,  sst_d;
  wmb_idx_t    sidx_q, sidx_d;
  wmb_word_t   sbuf_q, sbuf_d;
  logic        tf_q,   tf_d;
  logic        te_q,   te_d;
  logic        rd_q,   rd_d;
  logic        ld_q,   ld_d;
  logic        sc_q,   sc_d;
  wmb_piece_t  swd_q,  swd_d;
  logic        swr_q,  swr_d;
  logic        srv_q,  srv_d;
  logic        s_last;

  assign s_last = (sidx_q == wmb_last_idx(SAT_MODE));

  always_comb begin
    sst_d  = sst_q;
    sidx_d = sidx_q;
    sbuf_d = sbuf_q;
    tf_d   = 1'b0;
    te_d   = 1'b0;
    rd_d   = 1'b0;
    ld_d   = 1'b0;
    sc_d   = 1'b0;
    swd_d  = swd_q;
    swr_d  = 1'b0;
    srv_d  = 1'b0;
    unique case (sst_q)
      WMB_S_TOUT: begin
        sst_d = WMB_S_TIN;
        if (link.satellite_interrupt_request) begin
          tf_d  = 1'b1;
          sst_d = WMB_S_WOUT;
        end
      end
      WMB_S_WOUT: sst_d = WMB_S_KOUT;
      WMB_S_KOUT: begin
        sidx_d = '0;
        sst_d  = link.skip_request ? WMB_S_READ : WMB_S_TIN;
      end
      WMB_S_READ: begin
        rd_d  = 1'b1;
        sst_d = WMB_S_RWAIT;
      end
      WMB_S_RWAIT: sst_d = WMB_S_RGET;
      WMB_S_RGET: begin
        sbuf_d = wmb_piece_put(sbuf_q, link.sat_rdata, SAT_MODE, sidx_q);
        sidx_d = sidx_q + 2'h1;
        sst_d  = WMB_S_READ;
        if (s_last) begin
          srv_d = 1'b1;
          sst_d = WMB_S_TIN;
        end
      end
      WMB_S_TIN: begin
        sst_d = WMB_S_TOUT;
        if (sw_valid_i && link.satellite_interrupt_request) begin
          te_d  = 1'b1;
          sst_d = WMB_S_WIN;
        end
      end
      WMB_S_WIN: sst_d = WMB_S_KIN;
      WMB_S_KIN: begin
        sst_d = WMB_S_TOUT;
        if (link.skip_request) begin
          sbuf_d = sw_word_i;
          swr_d  = 1'b1;
          sc_d   = 1'b1;
          sidx_d = '0;
          sst_d  = WMB_S_LOAD;
        end
      end
      WMB_S_LOAD: begin
        ld_d   = 1'b1;
        swd_d  = wmb_piece_get(sbuf_q, SAT_MODE, sidx_q);
        sidx_d = sidx_q + 2'h1;
        if (s_last) begin
          sst_d = WMB_S_TOUT;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sst_q  <= WMB_S_TOUT;
      sidx_q <= '0;
      sbuf_q <= '0;
      tf_q   <= 1'b0;
      te_q   <= 1'b0;
      rd_q   <= 1'b0;
      ld_q   <= 1'b0;
      sc_q   <= 1'b0;
      swd_q  <= '0;
      swr_q  <= 1'b0;
      srv_q  <= 1'b0;
    end else begin
      sst_q  <= sst_d;
      sidx_q <= sidx_d;
      sbuf_q <= sbuf_d;
      tf_q   <= tf_d;
      te_q   <= te_d;
      rd_q   <= rd_d;
      ld_q   <= ld_d;
      sc_q   <= sc_d;
      swd_q  <= swd_d;
      swr_q  <= swr_d;
      srv_q  <= srv_d;
    end
  end

  // ==========================================================
  // Outputs
  assign link.host_sel       = clr_q || set_q || din_q || cin_q || cout_q;
  assign link.host_dout_clr  = clr_q;
  assign link.host_dout_set  = set_q;
  assign link.host_din       = din_q;
  assign link.host_cin       = cin_q;
  assign link.host_cout      = cout_q;
  assign link.host_wdata     = hwd_q;
  assign link.sat_test_full  = tf_q;
  assign link.sat_test_empty = te_q;
  assign link.sat_read       = rd_q;
  assign link.sat_load       = ld_q;
  assign link.sat_clear      = sc_q;
  assign link.sat_wdata      = swd_q;
  assign hw_ready_o          = hwr_q;
  assign hr_valid_o          = hrv_q;
  assign hr_word_o           = hrw_q;
  assign sw_ready_o          = swr_q;
  assign sr_valid_o          = srv_q;
  assign sr_word_o           = sbuf_q;
endmodule

// *** verilog/wmb_consts.svh ***
// Constants of the word width mailbox bridge
`ifndef WMB_CONSTS_SVH
`define WMB_CONSTS_SVH
// ==========================================================
// Widths and depths
`define WMB_WORD_W        36
`define WMB_SAT_W         18
`define WMB_FIFO_DEPTH    16
// ==========================================================
// Status word bit positions
`define WMB_ST_OUT_EMPTY  28
`define WMB_ST_OUT_FULL   29
`define WMB_ST_IN_FULL    30
`define WMB_ST_IN_EMPTY   31
`define WMB_ST_LOADING    32
// ==========================================================
// Reset values of the flags
`define WMB_RST_OUT_EMPTY 1'b1
`define WMB_RST_OUT_FULL  1'b0
`define WMB_RST_IN_FULL   1'b0
`define WMB_RST_IN_EMPTY  1'b1
`define WMB_RST_LOADING   1'b0
// ==========================================================
// Piece counts: index of the last piece per mode
`define WMB_LAST_IDX_12   2'h2
`define WMB_LAST_IDX_18   2'h1
// ==========================================================
// Timing
`define WMB_CLK_PERIOD_NS 8
`define WMB_DOUT_GAP_NS   1000
`define WMB_DOUT_GAP_CYC  ((`WMB_DOUT_GAP_NS + `WMB_CLK_PERIOD_NS - 1) / `WMB_CLK_PERIOD_NS)
`endif

// *** verilog/wmb_link_if.sv ***
// Link between the bridge device and the host and satellite processors
interface wmb_link_if;
  import wmb_pkg::*;
  // Host instruction pulses and data
  logic       host_sel;
  logic       host_dout_clr;
  logic       host_dout_set;
  logic       host_din;
  logic       host_cin;
  logic       host_cout;
  wmb_word_t  host_wdata;
  wmb_word_t  host_rdata;
  logic       host_rdata_vld;
  logic       host_interrupt_request;
  // Satellite instruction pulses and data
  logic       sat_test_full;
  logic       sat_test_empty;
  logic       sat_read;
  logic       sat_load;
  logic       sat_clear;
  wmb_piece_t sat_wdata;
  wmb_piece_t sat_rdata;
  logic       skip_request;
  logic       satellite_interrupt_request;
  logic       read_request;

  modport dev (
    input  host_sel, host_dout_clr, host_dout_set, host_din, host_cin, host_cout,
    input  host_wdata, sat_test_full, sat_test_empty, sat_read, sat_load, sat_clear,
    input  sat_wdata,
    output host_rdata, host_rdata_vld, host_interrupt_request, sat_rdata, skip_request,
    output satellite_interrupt_request, read_request
  );

  modport far (
    output host_sel, host_dout_clr, host_dout_set, host_din, host_cin, host_cout,
    output host_wdata, sat_test_full, sat_test_empty, sat_read, sat_load, sat_clear,
    output sat_wdata,
    input  host_rdata, host_rdata_vld, host_interrupt_request, sat_rdata, skip_request,
    input  satellite_interrupt_request, read_request
  );
endinterface

// *** verilog/wmb_pkg.sv ***
// Types and piece helpers of the word width mailbox bridge
`include "wmb_consts.svh"
package wmb_pkg;
  typedef logic [`WMB_WORD_W-1:0] wmb_word_t;
  typedef logic [`WMB_SAT_W-1:0]  wmb_piece_t;
  typedef logic [1:0]             wmb_idx_t;

  typedef enum logic [0:0] {
    WMB_MODE_12 = 1'b0,
    WMB_MODE_18 = 1'b1
  } wmb_mode_e;

  typedef enum logic [3:0] {
    WMB_H_POLL  = 4'h1,
    WMB_H_STAT  = 4'h2,
    WMB_H_GAP   = 4'h4,
    WMB_H_DWAIT = 4'h8
  } wmb_host_st_e;

  typedef enum logic [9:0] {
    WMB_S_TOUT  = 10'h001,
    WMB_S_WOUT  = 10'h002,
    WMB_S_KOUT  = 10'h004,
    WMB_S_READ  = 10'h008,
    WMB_S_RWAIT = 10'h010,
    WMB_S_RGET  = 10'h020,
    WMB_S_TIN   = 10'h040,
    WMB_S_WIN   = 10'h080,
    WMB_S_KIN   = 10'h100,
    WMB_S_LOAD  = 10'h200
  } wmb_sat_st_e;

  function automatic wmb_idx_t wmb_last_idx(wmb_mode_e m);
    return (m == WMB_MODE_12) ? `WMB_LAST_IDX_12 : `WMB_LAST_IDX_18;
  endfunction

  // Piece i of a word: 12 or 18 bits, lowest piece first
  function automatic wmb_piece_t wmb_piece_get(wmb_word_t w, wmb_mode_e m, wmb_idx_t i);
    wmb_word_t s;
    s = w >> ((m == WMB_MODE_12) ? 12 * i : 18 * i);
    return (m == WMB_MODE_12) ? {6'h00, s[11:0]} : s[17:0];
  endfunction

  // Word with piece i replaced
  function automatic wmb_word_t wmb_piece_put(wmb_word_t w, wmb_piece_t p, wmb_mode_e m,
                                              wmb_idx_t i);
    wmb_word_t mask;
    wmb_word_t val;
    int        sh;
    sh   = (m == WMB_MODE_12) ? 12 * i : 18 * i;
    mask = ((m == WMB_MODE_12) ? 36'h000000FFF : 36'h00003FFFF) << sh;
    val  = ((m == WMB_MODE_12) ? {24'h000000, p[11:0]} : {18'h00000, p}) << sh;
    return (w & ~mask) | (val & mask);
  endfunction
endpackage
